// [hw/fpc_consts.svh]
// Purpose: Constants for the fan pulse channel control block
// Assumes: 200 MHz system clock, 8-bit register port at fixed offsets
// Notes: Offsets, bit positions, reset values and timing tables
//
// Behaviour
// - Override enabled: requested duty is the override duty code, bits 7:4
// - Invert clear: full duty is steady high; invert set: steady low
// - Lock enabled: bound processor-hot event sets lock status bit 3
// - Lock enable clear: lock status never gets set
// - Lock status set: output held at full duty over every request
// - Lock status clears only by software writing zero; then normal duty
// - Lock status stays writable while global configuration lock is set
// - Override duty field accepts all sixteen codes through the duty table
// - Reading override duty field returns the duty code now in use
// - Override duty field reads zero while spin-up runs
// - During spin-up the channel uses the spin-up duty code, bits 3:0
// - Spin-up duty code zero disables spin-up
// - Requested duty going zero to non-zero starts spin-up for its duration
// - Duration code: 0 off, 100, 250, 400, 700, 1000, 2000, 4000 ms
// - Frequency code: 22500, 96, 84, 72, 60, 48, 36, 12 Hz
// - Largest duty requested among bound sources is applied
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// Register offsets
`define FPC_ADDR_OVR_LOCK 8'hc9
`define FPC_ADDR_SPINUP 8'hca
`define FPC_ADDR_FREQ 8'hcb

// Reset values
`define FPC_RST_OVR_LOCK 8'h00
`define FPC_RST_SPINUP 8'h00
`define FPC_RST_FREQ 8'h00

// Field positions
`define FPC_BIT_OVR_EN 0
`define FPC_BIT_INV 1
`define FPC_BIT_LOCK_EN 2
`define FPC_BIT_LOCK_ST 3
`define FPC_OVR_CODE_LSB 4
`define FPC_SU_DUTY_LSB 0
`define FPC_SPINUP_DURATION_CODE_LSB 5
`define FPC_FREQ_LSB 0

// Duty table: code / full code
`define FPC_DUTY_FULL 4'hf

// Clock and time units
`define FPC_CLK_HZ 200000000
`define FPC_MS_PER_S 1000

// Spin-up durations in ms
`define FPC_SU_MS_1 100
`define FPC_SU_MS_2 250
`define FPC_SU_MS_3 400
`define FPC_SU_MS_4 700
`define FPC_SU_MS_5 1000
`define FPC_SU_MS_6 2000
`define FPC_SU_MS_7 4000

// Output frequencies in Hz
`define FPC_HZ_0 22500
`define FPC_HZ_1 96
`define FPC_HZ_2 84
`define FPC_HZ_3 72
`define FPC_HZ_4 60
`define FPC_HZ_5 48
`define FPC_HZ_6 36
`define FPC_HZ_7 12

`endif

// [hw/fpc_pkg.sv]
// Purpose: Types shared by the fan pulse channel control files
// Assumes: Constants come from fpc_consts.svh
// Notes: Types only
package fpc_pkg;

  // One register access, taken in a single cycle
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpc_req_s;

  typedef enum logic {SPIN_IDLE, SPIN_RUN} fpc_spin_e;

  // Whole state of the control module
  typedef struct packed {
    logic ovr_en;
    logic output_polarity_invert;
    logic lock_en;
    logic lock_st;
    logic [3:0] ovr_code;
    logic [3:0] su_duty;
    logic [2:0] spinup_duration_code;
    logic [2:0] freq;
    logic [1:0] hot_sync;
    fpc_spin_e spin;
    logic [31:0] spin_cnt;
    logic [3:0] req_prev;
    logic [7:0] rdata;
  } fpc_state_s;

  // Whole state of the pulse generator
  typedef struct packed {
    logic [31:0] cnt;
    logic pulse;
  } fpc_gen_s;

endpackage : fpc_pkg

// [hw/fpc_pulse_gen.sv]
// Purpose: Pulse waveform from a period count and a duty code
// Assumes: Period and code come from logic on the same clock
// Notes: Code 15 is steady on, code 0 steady off
`timescale 1ns/100ps
`default_nettype none
`include "fpc_consts.svh"

module fpc_pulse_gen
  import fpc_pkg::*;
#(
  parameter int CW = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [CW-1:0] period,
  input wire logic [3:0] duty_code,
  input wire logic invert,
  output logic pulse
);

  if (CW < 8 || CW > 32) begin : g_chk
    $error("fpc_pulse_gen: CW out of range");
  end

  fpc_gen_s st_q;
  fpc_gen_s st_d;
  logic [CW+3:0] prod;
  logic [CW+3:0] high_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // High time scales with code over full code; full code covers whole period
  always_comb begin
    prod = (CW+4)'(period) * (CW+4)'(duty_code);
    high_cnt = prod / (CW+4)'(`FPC_DUTY_FULL);
    st_d = st_q;
    // Wrap at period end; a shorter new period also wraps at once
    if (32'(st_q.cnt) + 32'd1 >= 32'(period)) begin
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 32'd1;
    end
    // Full code forced on: a shortened period leaves cnt past its end once
    st_d.pulse = ((duty_code == `FPC_DUTY_FULL)
                  || ((CW+4)'(st_q.cnt) < high_cnt)) ^ invert;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

endmodule : fpc_pulse_gen
`default_nettype wire

// [hw/fpc_channel.sv]
// Purpose: Fan pulse channel one control: override, lock, spin-up, frequency
// Assumes: Register port is single-cycle; other sources arrive on sys_clk
// Notes: Processor-hot pin is synchronised; reads answer one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "fpc_consts.svh"

module fpc_channel
  import fpc_pkg::*;
#(
  parameter int CLK_HZ = `FPC_CLK_HZ,
  parameter int CYC_PER_MS = `FPC_CLK_HZ / `FPC_MS_PER_S
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fpc_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic cfg_lock,
  input wire logic hot_bound,
  input wire logic processor_hot_event,
  input wire logic [3:0] source_duty_code,
  output logic [3:0] duty_code_in_use,
  output logic spinup_active,
  output logic fan_pulse_output_one
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: fastest rate must still give a period above one
  if (CLK_HZ < `FPC_HZ_0 * 2) begin : g_chk_clk
    $error("fpc_channel: CLK_HZ too low for fastest output rate");
  end
  if (CYC_PER_MS < 1 || CYC_PER_MS > 500000) begin : g_chk_ms
    $error("fpc_channel: CYC_PER_MS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table functions

  // Duration in ms; code 0 gives zero, meaning spin-up disabled
  function automatic logic [31:0] spin_ms(input logic [2:0] code);
    logic [31:0] ms;
    unique case (code)
      3'h0: ms = 32'd0;
      3'h1: ms = 32'(`FPC_SU_MS_1);
      3'h2: ms = 32'(`FPC_SU_MS_2);
      3'h3: ms = 32'(`FPC_SU_MS_3);
      3'h4: ms = 32'(`FPC_SU_MS_4);
      3'h5: ms = 32'(`FPC_SU_MS_5);
      3'h6: ms = 32'(`FPC_SU_MS_6);
      3'h7: ms = 32'(`FPC_SU_MS_7);
    endcase
    return ms;
  endfunction : spin_ms

  // Output rate in Hz
  function automatic logic [31:0] freq_hz(input logic [2:0] code);
    logic [31:0] hz;
    unique case (code)
      3'h0: hz = 32'(`FPC_HZ_0);
      3'h1: hz = 32'(`FPC_HZ_1);
      3'h2: hz = 32'(`FPC_HZ_2);
      3'h3: hz = 32'(`FPC_HZ_3);
      3'h4: hz = 32'(`FPC_HZ_4);
      3'h5: hz = 32'(`FPC_HZ_5);
      3'h6: hz = 32'(`FPC_HZ_6);
      3'h7: hz = 32'(`FPC_HZ_7);
    endcase
    return hz;
  endfunction : freq_hz

  // Larger of two duty codes
  function automatic logic [3:0] max_code(input logic [3:0] a, input logic [3:0] b);
    return (a > b) ? a : b;
  endfunction : max_code

  ////////////////////////////////////////////////////////////////////////////
  // State

  fpc_state_s st_q;
  fpc_state_s st_d;
  logic [3:0] raw_req;
  logic [3:0] use_code;
  logic [3:0] rd_code;
  logic hot_set;
  logic spin_start;
  logic wr_ovr;
  logic wr_su;
  logic wr_freq;
  logic [31:0] spin_total;
  logic [31:0] period_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // Duty selection: largest bound request, then spin-up, then lock on top
  always_comb begin
    raw_req = max_code(st_q.ovr_en ? st_q.ovr_code : 4'h0, source_duty_code);
    if (st_q.lock_st) begin
      use_code = `FPC_DUTY_FULL;
    end else if (st_q.spin == SPIN_RUN) begin
      use_code = st_q.su_duty;
    end else begin
      use_code = raw_req;
    end
    // Readback shows what drives the pin, or zero during spin-up, not what was last written
    rd_code = (st_q.spin == SPIN_RUN) ? 4'h0 : use_code;
  end

  // Event and access decode
  assign hot_set = st_q.lock_en && hot_bound && st_q.hot_sync[1];
  assign wr_ovr = reg_req.wr_en && (reg_req.addr == `FPC_ADDR_OVR_LOCK);
  assign wr_su = reg_req.wr_en && (reg_req.addr == `FPC_ADDR_SPINUP) && !cfg_lock;
  assign wr_freq = reg_req.wr_en && (reg_req.addr == `FPC_ADDR_FREQ) && !cfg_lock;

  // Spin-up starts only on a zero to non-zero edge with both fields non-zero
  assign spin_start = (raw_req != 4'h0) && (st_q.req_prev == 4'h0)
                      && (st_q.su_duty != 4'h0) && (st_q.spinup_duration_code != 3'h0);

  // Multiply stays in 32 bits for the documented clock; checked above
  assign spin_total = spin_ms(st_q.spinup_duration_code) * 32'(CYC_PER_MS);
  assign period_cyc = 32'(CLK_HZ) / freq_hz(st_q.freq);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_d = st_q;
    // Second stage is the only reader of the first
    st_d.hot_sync = {st_q.hot_sync[0], processor_hot_event};
    st_d.req_prev = raw_req;

    // Control register: configuration bits obey the global lock
    if (wr_ovr && !cfg_lock) begin
      st_d.ovr_en = reg_req.wdata[`FPC_BIT_OVR_EN];
      st_d.output_polarity_invert = reg_req.wdata[`FPC_BIT_INV];
      st_d.lock_en = reg_req.wdata[`FPC_BIT_LOCK_EN];
      st_d.ovr_code = reg_req.wdata[`FPC_OVR_CODE_LSB +: 4];
    end
    // Lock status: write of zero clears even under global lock; set wins
    if (wr_ovr && !reg_req.wdata[`FPC_BIT_LOCK_ST]) begin
      st_d.lock_st = 1'b0;
    end
    if (hot_set) begin
      st_d.lock_st = 1'b1;
    end

    // Reserved bit 4 of spin-up and bits 7:3 of frequency are never stored
    if (wr_su) begin
      st_d.su_duty = reg_req.wdata[`FPC_SU_DUTY_LSB +: 4];
      st_d.spinup_duration_code = reg_req.wdata[`FPC_SPINUP_DURATION_CODE_LSB +: 3];
    end
    if (wr_freq) begin
      st_d.freq = reg_req.wdata[`FPC_FREQ_LSB +: 3];
    end

    // Spin-up timer; a drop of the request back to zero ends it early
    unique case (st_q.spin)
      SPIN_IDLE: begin
        if (spin_start) begin
          st_d.spin = SPIN_RUN;
          st_d.spin_cnt = spin_total - 32'd1;
        end
      end
      SPIN_RUN: begin
        if (raw_req == 4'h0 || st_q.spin_cnt == 32'd0) begin
          st_d.spin = SPIN_IDLE;
        end else begin
          st_d.spin_cnt = st_q.spin_cnt - 32'd1;
        end
      end
    endcase

    // Read data latched for the following cycle
    if (reg_req.rd_en) begin
      unique case (reg_req.addr)
        `FPC_ADDR_OVR_LOCK: st_d.rdata = {rd_code, st_q.lock_st, st_q.lock_en,
                                          st_q.output_polarity_invert, st_q.ovr_en};
        `FPC_ADDR_SPINUP: st_d.rdata = {st_q.spinup_duration_code, 1'b0, st_q.su_duty};
        `FPC_ADDR_FREQ: st_d.rdata = {5'h00, st_q.freq};
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register: all fields reset to zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generator
  fpc_pulse_gen #(
    .CW(32)
  ) u_gen (
    .sys_clk(sys_clk),
    .rst(rst),
    .period(period_cyc),
    .duty_code(use_code),
    .invert(st_q.output_polarity_invert),
    .pulse(fan_pulse_output_one)
  );

  // Outputs
  assign reg_rdata = st_q.rdata;
  assign duty_code_in_use = use_code;
  assign spinup_active = (st_q.spin == SPIN_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_req_rises;
    (raw_req == 4'h0) ##1 (raw_req != 4'h0);
  endsequence

  sequence s_spin_armed;
    (st_q.su_duty != 4'h0) && (st_q.spinup_duration_code != 3'h0) && (st_q.spin == SPIN_IDLE);
  endsequence

  a_ovr_duty_use: assert property (
    st_q.ovr_en && !st_q.lock_st && st_q.spin == SPIN_IDLE
      && source_duty_code <= st_q.ovr_code |-> use_code == st_q.ovr_code)
    else $error("override code not in use");

  a_full_high: assert property (
    (use_code == 4'hf && !st_q.output_polarity_invert)[*3] |-> fan_pulse_output_one)
    else $error("full duty not steady high");

  a_full_low: assert property (
    (use_code == 4'hf && st_q.output_polarity_invert)[*3] |-> !fan_pulse_output_one)
    else $error("inverted full duty not steady low");

  a_lock_set: assert property (
    hot_set |=> st_q.lock_st)
    else $error("hot event did not set lock");

  a_lock_never: assert property (
    $rose(st_q.lock_st) |-> $past(st_q.lock_en) && $past(st_q.hot_sync[1]))
    else $error("lock set without enable or event");

  a_lock_full: assert property (
    st_q.lock_st |-> use_code == 4'hf)
    else $error("lock not at full duty");

  a_lock_clear: assert property (
    $fell(st_q.lock_st) |-> $past(wr_ovr) && !$past(reg_req.wdata[3]))
    else $error("lock cleared without zero write");

  a_lock_cfg: assert property (
    wr_ovr && cfg_lock && !reg_req.wdata[3] && !hot_set |=> !st_q.lock_st)
    else $error("lock not clearable under config lock");

  a_ovr_read: assert property (
    reg_req.rd_en && reg_req.addr == 8'hc9 && st_q.spin == SPIN_IDLE
      |=> reg_rdata[7:4] == $past(use_code))
    else $error("readback not code in use");

  a_spin_read: assert property (
    reg_req.rd_en && reg_req.addr == 8'hc9 && st_q.spin == SPIN_RUN
      |=> reg_rdata[7:4] == 4'h0)
    else $error("readback not zero in spin-up");

  a_spin_duty: assert property (
    st_q.spin == SPIN_RUN && !st_q.lock_st |-> use_code == st_q.su_duty)
    else $error("spin-up duty not used");

  a_spin_off: assert property (
    st_q.spin == SPIN_IDLE && st_q.su_duty == 4'h0 |=> st_q.spin == SPIN_IDLE)
    else $error("spin-up ran with zero duty");

  a_spin_start: assert property (
    s_req_rises ##0 s_spin_armed |=> st_q.spin == SPIN_RUN)
    else $error("spin-up not started");

  a_spin_len: assert property (
    $rose(st_q.spin == SPIN_RUN) |-> st_q.spin_cnt == $past(spin_total) - 32'd1)
    else $error("spin-up length wrong");

  a_resv_read: assert property (
    reg_req.rd_en && reg_req.addr == 8'hcb |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved bits not zero");

  a_largest: assert property (
    !st_q.lock_st && st_q.spin == SPIN_IDLE |-> use_code >= source_duty_code)
    else $error("smaller request won");

endmodule : fpc_channel
`default_nettype wire

// [bench/fpc_fan_model.sv]
// Purpose: Fan driver model that measures the pulse it receives
// Assumes: Pulse sampled on sys_clk
// Notes: Reports the last full period and its high time
`timescale 1ns/100ps
`default_nettype none

module fpc_fan_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fan_pulse_output_one,
  output logic [31:0] period_q,
  output logic [31:0] high_q
);
  logic [31:0] cnt_q;
  logic [31:0] hc_q;
  logic prev_q;

  ////////////////////////////////////////////////////////////////
  // Rising edge to rising edge; steady levels never update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      hc_q <= '0;
      prev_q <= 1'b0;
      period_q <= '0;
      high_q <= '0;
    end else begin
      prev_q <= fan_pulse_output_one;
      if (fan_pulse_output_one && !prev_q) begin
        period_q <= cnt_q + 32'd1;
        high_q <= hc_q;
        cnt_q <= '0;
        hc_q <= 32'd1;
      end else begin
        cnt_q <= cnt_q + 32'd1;
        hc_q <= hc_q + {31'd0, fan_pulse_output_one};
      end
    end
  end
endmodule : fpc_fan_model

`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the fan pulse channel control
// Assumes: Shortened clock constants, period 20 cycles at code 0
// Notes: Register tasks follow the one-cycle strobe protocol
`timescale 1ns/100ps
`default_nettype none
`include "fpc_consts.svh"

module tb
  import fpc_pkg::*;
;
  localparam int CHZ = 450000;
  localparam int CPM = 10;
  logic sys_clk, rst, cfg_lock, hot_bound, hot, spin, fan;
  fpc_req_s req;
  logic [3:0] src, in_use;
  logic [7:0] rdata;
  logic [31:0] per, hi;
  int err_total, n_tests, spin_n, n;
  int su_ms[8] = '{0, 100, 250, 400, 700, 1000, 2000, 4000};

  fpc_channel #(.CLK_HZ(CHZ), .CYC_PER_MS(CPM)) dut (
    .sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
    .cfg_lock(cfg_lock), .hot_bound(hot_bound), .processor_hot_event(hot),
    .source_duty_code(src), .duty_code_in_use(in_use),
    .spinup_active(spin), .fan_pulse_output_one(fan)
  );

  fpc_fan_model fan_i (
    .sys_clk(sys_clk), .rst(rst), .fan_pulse_output_one(fan),
    .period_q(per), .high_q(hi)
  );

  ////////////////////////////////////////////////////////////////
  // Clock, and spin-up length counted from pre-edge values
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) if (spin === 1'b1) spin_n++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    req <= '0;
  endtask : wr

  // Data lands at the edge that takes the read and holds; look one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
    @(posedge sys_clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
    chk({24'd0, rdata}, {24'd0, e}, m);
  endtask : rd

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////
  // Watchdog: tests need about 28k cycles, limit at 60k
  initial begin
    #300000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    req = '0;
    cfg_lock = 1'b0;
    hot_bound = 1'b0;
    hot = 1'b0;
    src = 4'h0;
    spin_n = 0;
    cyc(8);
    rst <= 1'b0;
    // Reset values, unmapped place, reserved bits
    rd(`FPC_ADDR_OVR_LOCK, 8'h00, "c9 reset");
    rd(`FPC_ADDR_SPINUP, 8'h00, "ca reset");
    rd(`FPC_ADDR_FREQ, 8'h00, "cb reset");
    wr(8'hc8, 8'hff);
    rd(8'hc8, 8'h00, "unmapped");
    wr(`FPC_ADDR_SPINUP, 8'hf0);
    rd(`FPC_ADDR_SPINUP, 8'he0, "ca reserved");
    wr(`FPC_ADDR_FREQ, 8'hff);
    rd(`FPC_ADDR_FREQ, 8'h07, "cb reserved");
    wr(`FPC_ADDR_SPINUP, 8'h00);
    wr(`FPC_ADDR_FREQ, 8'h00);
    $display("test registers done");
    // Every override code at 20-cycle period
    for (int c = 0; c < 16; c++) begin
      wr(`FPC_ADDR_OVR_LOCK, {c[3:0], 4'h1});
      cyc(70);
      #1;
      chk({28'd0, in_use}, c, "in use");
      if (c == 0 || c == 15) chk({31'd0, fan}, c == 15, "steady");
      else chk(hi, 20 * c / 15, "high");
      if (c == 5) chk(per, CHZ / 22500, "period");
      rd(`FPC_ADDR_OVR_LOCK, {c[3:0], 4'h1}, "c9 code");
    end
    wr(`FPC_ADDR_OVR_LOCK, 8'hf3);
    cyc(70);
    #1;
    chk({31'd0, fan}, 0, "inverted full");
    // Larger source request wins
    wr(`FPC_ADDR_OVR_LOCK, 8'h31);
    src <= 4'h9;
    cyc(3);
    #1;
    chk({28'd0, in_use}, 9, "max source");
    rd(`FPC_ADDR_OVR_LOCK, 8'h91, "c9 max");
    src <= 4'h0;
    $display("test duty done");
    // Hot lock
    hot_bound <= 1'b1;
    wr(`FPC_ADDR_OVR_LOCK, 8'h11);
    hot <= 1'b1;
    cyc(6);
    hot <= 1'b0;
    cyc(4);
    rd(`FPC_ADDR_OVR_LOCK, 8'h11, "no lock");
    wr(`FPC_ADDR_OVR_LOCK, 8'h15);
    hot <= 1'b1;
    cyc(6);
    hot <= 1'b0;
    cyc(70);
    #1;
    chk({28'd0, in_use}, 15, "lock duty");
    chk({31'd0, fan}, 1, "lock full");
    rd(`FPC_ADDR_OVR_LOCK, 8'hfd, "lock set");
    cfg_lock <= 1'b1;
    wr(`FPC_ADDR_OVR_LOCK, 8'h00);
    rd(`FPC_ADDR_OVR_LOCK, 8'h15, "lock clear");
    wr(`FPC_ADDR_SPINUP, 8'h21);
    rd(`FPC_ADDR_SPINUP, 8'h00, "cfg locked");
    cfg_lock <= 1'b0;
    wr(`FPC_ADDR_OVR_LOCK, 8'h00);
    $display("test lock done");
    // Frequency code 3
    wr(`FPC_ADDR_FREQ, 8'h03);
    wr(`FPC_ADDR_OVR_LOCK, 8'h51);
    cyc(3 * (CHZ / 72));
    #1;
    chk(per, CHZ / 72, "period 72");
    chk(hi, (CHZ / 72) * 5 / 15, "high 72");
    wr(`FPC_ADDR_OVR_LOCK, 8'h00);
    wr(`FPC_ADDR_FREQ, 8'h00);
    $display("test frequency done");
    // Spin-up durations 1..3
    for (int d = 1; d < 4; d++) begin
      wr(`FPC_ADDR_SPINUP, {d[2:0], 5'h04});
      spin_n = 0;
      src <= 4'h6;
      cyc(3);
      #1;
      chk({28'd0, in_use}, 4, "spin duty");
      rd(`FPC_ADDR_OVR_LOCK, 8'h00, "spin read");
      n = 0;
      while (spin !== 1'b0 && n < 50000) begin
        cyc(1);
        n++;
      end
      cyc(2);
      chk(spin_n, su_ms[d] * CPM, "spin length");
      src <= 4'h0;
      cyc(3);
    end
    wr(`FPC_ADDR_SPINUP, 8'h20);
    spin_n = 0;
    src <= 4'h6;
    cyc(20);
    #1;
    chk(spin_n, 0, "spin off");
    chk({28'd0, in_use}, 6, "no spin duty");
    $display("test spinup done");
    results();
  end
endmodule : tb

`default_nettype wire
